// ===== conv_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl #(
   parameter longint step_cycles = conv_ctrl_pkg::step_cycles,
   parameter int conv_cycles = conv_ctrl_pkg::conv_cycles_default
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port from the serial interface
   input wire logic reg_wr,
   input wire logic [7:0] reg_ptr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // comparator outputs, from pins
   input wire logic cmp_out_a,
   input wire logic cmp_out_b,
   // converter control
   output logic converting,
   output logic conv_channel,
   output logic analog_power_on
);

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] power_down_timer;
   logic [7:0] converter_configuration;
   logic [7:0] next_power_down_timer;
   logic [7:0] next_converter_configuration;

   // ----------------------------------------
   // comparator synchronisers (three stages)
   // ----------------------------------------
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic cmp_a_q; // accepted level
   logic cmp_b_q;
   logic next_cmp_a_q;
   logic next_cmp_b_q;
   logic activity; // rising edge on either comparator

   // ----------------------------------------
   // conversion sequencer
   // ----------------------------------------
   typedef enum logic [1:0] {
      seq_idle = 2'b00,
      seq_convert = 2'b01,
      seq_off = 2'b10
   } seq_t;
   seq_t state;
   seq_t next_state;
   logic [31:0] conv_count;
   logic [31:0] next_conv_count;
   logic channel;
   logic next_channel;
   logic first_done; // single mode: first channel finished
   logic next_first_done;
   logic single_spent; // single mode: pass finished, waits for another mode
   logic next_single_spent;
   logic expired;
   logic timer_write;
   logic [2:0] mode;
   logic ch1_en;
   logic ch2_en;

   assign timer_write = reg_wr && (reg_ptr == conv_ctrl_pkg::ptr_power_down_timer);
   assign mode = converter_configuration[conv_ctrl_pkg::op_mode_lsb +:
                                         conv_ctrl_pkg::op_mode_width];
   assign ch1_en = converter_configuration[conv_ctrl_pkg::first_channel_enable_bit];
   assign ch2_en = converter_configuration[conv_ctrl_pkg::second_channel_enable_bit];

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // timer stores all 8 bits; bits 7 and 6 are the host's duty
   always_comb begin
      next_power_down_timer = power_down_timer;
      next_converter_configuration = converter_configuration;
      if (timer_write) begin
         next_power_down_timer = reg_wdata;
      end
      if (reg_wr && reg_ptr == conv_ctrl_pkg::ptr_converter_configuration) begin
         // reserved modes are not filtered; host must avoid them
         next_converter_configuration = reg_wdata;
      end
      if (expired) begin
         // auto power-down rewrites the mode so software sees it
         next_converter_configuration[conv_ctrl_pkg::op_mode_lsb +:
            conv_ctrl_pkg::op_mode_width] = conv_ctrl_pkg::mode_power_down;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         power_down_timer <= conv_ctrl_pkg::timer_reset;
         converter_configuration <= conv_ctrl_pkg::config_reset;
      end else begin
         power_down_timer <= next_power_down_timer;
         converter_configuration <= next_converter_configuration;
      end
   end

   // read mux, registered; unmapped pointers read zero
   always_ff @(posedge clk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_ptr == conv_ctrl_pkg::ptr_power_down_timer) begin
         reg_rdata <= power_down_timer;
      end else if (reg_ptr == conv_ctrl_pkg::ptr_converter_configuration) begin
         reg_rdata <= converter_configuration;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // comparator activity
   // ----------------------------------------
   // a change counts once stages two and three agree; stage one feeds only stage two
   always_comb begin
      next_cmp_a_q = cmp_a_q;
      next_cmp_b_q = cmp_b_q;
      if (sync_a[1] == sync_a[2]) begin
         next_cmp_a_q = sync_a[2];
      end
      if (sync_b[1] == sync_b[2]) begin
         next_cmp_b_q = sync_b[2];
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
         cmp_a_q <= 1'b0;
         cmp_b_q <= 1'b0;
      end else begin
         sync_a <= {sync_a[1:0], cmp_out_a};
         sync_b <= {sync_b[1:0], cmp_out_b};
         cmp_a_q <= next_cmp_a_q;
         cmp_b_q <= next_cmp_b_q;
      end
   end

   assign activity = (next_cmp_a_q && !cmp_a_q) || (next_cmp_b_q && !cmp_b_q);

   // ----------------------------------------
   // inactivity timer
   // ----------------------------------------
   // only runs while not already powered down; a timer write or a comparator rising edge restarts it
   inactivity_timer #(
      .step_cycles(step_cycles),
      .timeout_width(conv_ctrl_pkg::timeout_width)
   ) u_timer (
      .clk(clk),
      .rstn(rstn),
      .timeout(power_down_timer[conv_ctrl_pkg::timeout_width-1:0]),
      .restart(activity || timer_write),
      .armed(mode != conv_ctrl_pkg::mode_power_down),
      .expired(expired)
   );

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // channel order is 1 then 2; disabled channels are skipped
   always_comb begin
      next_state = state;
      next_conv_count = conv_count;
      next_channel = channel;
      next_first_done = first_done;
      // leaving single mode re-arms the next pass; staying in it holds the sequencer idle
      next_single_spent = single_spent && (mode == conv_ctrl_pkg::mode_single);
      unique case (state)
         seq_idle: begin
            next_conv_count = '0;
            next_first_done = 1'b0;
            next_channel = !ch1_en && ch2_en;
            if (mode == conv_ctrl_pkg::mode_power_down) begin
               next_state = seq_off;
            end else if ((mode == conv_ctrl_pkg::mode_continuous ||
                          (mode == conv_ctrl_pkg::mode_single && !single_spent)) &&
                         (ch1_en || ch2_en)) begin
               next_state = seq_convert;
            end else begin
               next_state = seq_idle; // powered but idle
            end
         end
         seq_convert: begin
            if (mode == conv_ctrl_pkg::mode_power_down) begin
               next_state = seq_off;
            end else if (mode == conv_ctrl_pkg::mode_idle) begin
               next_state = seq_idle;
            end else if (conv_count == 32'(conv_cycles - 1)) begin
               next_conv_count = '0;
               // alternate only when both channels are on
               next_channel = (ch1_en && ch2_en) ? !channel : (!ch1_en && ch2_en);
               if (mode == conv_ctrl_pkg::mode_single) begin
                  next_first_done = 1'b1;
                  if (!(ch1_en && ch2_en) || first_done) begin
                     next_state = seq_idle; // one per enabled channel
                     next_single_spent = 1'b1; // no second pass on the same 010
                  end
               end
            end else begin
               next_conv_count = conv_count + 32'h1;
            end
         end
         seq_off: begin
            // stays off until the host writes another mode
            next_conv_count = '0;
            if (mode != conv_ctrl_pkg::mode_power_down) begin
               next_state = seq_idle;
            end
         end
         default: begin
            next_state = seq_idle;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state <= seq_idle;
         conv_count <= '0;
         channel <= 1'b0;
         first_done <= 1'b0;
         single_spent <= 1'b0;
      end else begin
         state <= next_state;
         conv_count <= next_conv_count;
         channel <= next_channel;
         first_done <= next_first_done;
         single_spent <= next_single_spent;
      end
   end

   // after a single pass the field keeps 010; another pass needs a different mode first
   // outputs straight from flip-flops
   always_ff @(posedge clk) begin
      if (!rstn) begin
         converting <= 1'b0;
         conv_channel <= 1'b0;
         analog_power_on <= 1'b1;
      end else begin
         converting <= (next_state == seq_convert);
         conv_channel <= next_channel;
         analog_power_on <= (next_state != seq_off);
      end
   end

endmodule : conv_ctrl
`default_nettype wire

// ===== conv_ctrl_pkg.sv
package conv_ctrl_pkg;

   // ----------------------------------------
   // register pointers and reset values
   // ----------------------------------------
   localparam logic [7:0] ptr_power_down_timer = 8'h10;
   localparam logic [7:0] ptr_converter_configuration = 8'h0f;
   localparam logic [7:0] timer_reset = 8'h40;
   localparam logic [7:0] config_reset = 8'h19;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int second_channel_enable_bit = 3;
   localparam int first_channel_enable_bit = 4;
   localparam int op_mode_lsb = 0;
   localparam int op_mode_width = 3;
   localparam int timeout_width = 6;

   // ----------------------------------------
   // operating modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      mode_idle = 3'b000,
      mode_continuous = 3'b001,
      mode_single = 3'b010,
      mode_power_down = 3'b011
   } op_mode_t;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam longint step_hours = 4;
   localparam longint clk_mhz = 200;
   localparam longint step_cycles = step_hours * 64'd3600 * 64'd1000000 * clk_mhz;
   localparam int conv_cycles_default = 2000000;

endpackage : conv_ctrl_pkg

// ===== inactivity_timer.sv
`timescale 1ns/1ps
`default_nettype none
module inactivity_timer #(
   parameter longint step_cycles = conv_ctrl_pkg::step_cycles,
   parameter int timeout_width = conv_ctrl_pkg::timeout_width
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // control
   input wire logic [timeout_width-1:0] timeout,
   input wire logic restart,
   input wire logic armed,
   // result
   output logic expired
);

   // ----------------------------------------
   // counters
   // ----------------------------------------
   logic [47:0] step_count; // cycles inside one four-hour step
   logic [47:0] next_step_count;
   logic [timeout_width-1:0] steps; // whole steps elapsed
   logic [timeout_width-1:0] next_steps;
   logic next_expired;

   // count steps; zero timeout holds the counters at rest
   always_comb begin
      next_step_count = step_count;
      next_steps = steps;
      next_expired = 1'b0;
      if (restart || !armed || timeout == '0) begin
         next_step_count = '0;
         next_steps = '0;
      end else if (step_count == 48'(step_cycles - 1)) begin
         next_step_count = '0;
         next_steps = steps + 1'b1;
         // full period is timeout times the step, 0x3f the longest
         if (steps + 1'b1 == timeout) begin
            next_expired = 1'b1;
            next_steps = '0;
         end
      end else begin
         next_step_count = step_count + 1'b1;
      end
   end

   // register counters
   always_ff @(posedge clk) begin
      if (!rstn) begin
         step_count <= '0;
         steps <= '0;
         expired <= 1'b0;
      end else begin
         step_count <= next_step_count;
         steps <= next_steps;
         expired <= next_expired;
      end
   end

endmodule : inactivity_timer
`default_nettype wire

// ===== conv_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_chk #(
   parameter longint step_cycles = 10,
   parameter int conv_cycles = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic reg_wr,
   input wire logic [7:0] reg_ptr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // comparators and converter control
   input wire logic cmp_out_a,
   input wire logic cmp_out_b,
   input wire logic converting,
   input wire logic conv_channel,
   input wire logic analog_power_on
);
   localparam int alt_max = conv_cycles + 8;
   localparam int one_max = 3 * conv_cycles + 8;
   logic [7:0] cfg, tmr, s; // register mirrors, cycles since a config write
   logic [31:0] q; // cycles since the timer last restarted
   logic pa, pb, auto_pd;
   wire cw = reg_wr && reg_ptr == conv_ctrl_pkg::ptr_converter_configuration;
   wire tw = reg_wr && reg_ptr == conv_ctrl_pkg::ptr_power_down_timer;
   wire [2:0] md = auto_pd ? 3'h3 : cfg[2:0]; // mode the device should be in
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ---------------
   // mirrors
   // ---------------
   // a power fall with no power-down command is taken as the timer's doing
   always_ff @(posedge clk) begin
      pa <= cmp_out_a;
      pb <= cmp_out_b;
      if (!rstn) begin
         cfg <= conv_ctrl_pkg::config_reset;
         tmr <= conv_ctrl_pkg::timer_reset;
         s <= 8'h00;
         q <= 32'h0;
         auto_pd <= 1'b0;
      end else begin
         if (cw) cfg <= reg_wdata;
         if (tw) tmr <= reg_wdata;
         if (cw) auto_pd <= 1'b0;
         else if ($fell(analog_power_on) && cfg[2:0] != 3'h3) auto_pd <= 1'b1;
         if (cw) s <= 8'h00;
         else if (s != 8'hff) s <= s + 8'h01;
         // timer is frozen while powered down
         if (tw || (cmp_out_a && !pa) || (cmp_out_b && !pb)) q <= 32'h0;
         else if (analog_power_on) q <= q + 32'h1;
      end
   end
   // ---------------
   // properties
   // ---------------
   sequence s_one_go; cw && reg_wdata[2:0] == 3'h2 && cfg[2:0] != 3'h2; endsequence
   sequence s_one_done; (!converting) [*8]; endsequence
   property p_idle; md == 3'h0 && s > 3 |-> !converting && analog_power_on; endproperty
   property p_alt; converting && md == 3'h1 && cfg[4:3] == 2'b11 && s > 3
      |-> ##[1:alt_max] ($changed(conv_channel) || !analog_power_on || s < 3); endproperty
   property p_one; s_one_go |-> ##[1:4] converting ##[1:one_max] s_one_done; endproperty
   property p_pd; md == 3'h3 && s > 3 |-> !converting && !analog_power_on; endproperty
   property p_rd; (reg_ptr == 8'h10 && !reg_wr) [*2] |-> reg_rdata == tmr; endproperty
   property p_win; $fell(analog_power_on) && cfg[2:0] != 3'h3 && s > 3
      |-> q + 1 >= tmr[5:0] * step_cycles && q <= tmr[5:0] * step_cycles + 10; endproperty
   property p_zero; tmr[5:0] == 6'h00 && cfg[2:0] != 3'h3 && s > 3
      |-> !$fell(analog_power_on); endproperty
   property p_stay; auto_pd && !cw |=> !analog_power_on; endproperty
   property p_ch2; !cfg[3] && s > alt_max && converting |-> !conv_channel; endproperty
   a_idle: assert property (p_idle) else $error("idle mode converts");
   a_alt: assert property (p_alt) else $error("channels do not alternate");
   a_one: assert property (p_one) else $error("single pass wrong");
   a_pd: assert property (p_pd) else $error("power-down not honoured");
   a_rd: assert property (p_rd) else $error("timer readback wrong");
   a_win: assert property (p_win) else $error("auto power-down timing");
   a_zero: assert property (p_zero) else $error("zero timeout powered down");
   a_stay: assert property (p_stay) else $error("woke without command");
   a_ch2: assert property (p_ch2) else $error("disabled channel converted");
endmodule : conv_ctrl_chk
`default_nettype wire

// ===== host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock
   input wire logic clk,
   // register port towards the device
   output logic reg_wr,
   output logic [7:0] reg_ptr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_ptr = 8'h00;
      reg_wdata = 8'h00;
   end
   // one-cycle strobe launched just after an edge; the host never sends reserved codes
   task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
      logic [7:0] v;
      v = data;
      if (ptr == conv_ctrl_pkg::ptr_power_down_timer) v[7:6] = 2'b01;
      if (ptr == conv_ctrl_pkg::ptr_converter_configuration) v[2] = 1'b0;
      @(posedge clk);
      #1;
      reg_wr = 1'b1;
      reg_ptr = ptr;
      reg_wdata = v;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~v; // no stale copy left on released data
   endtask : wr
   // read data is registered, so wait two edges before taking it
   task automatic rd(input logic [7:0] ptr, output logic [7:0] data);
      @(posedge clk);
      #1;
      reg_ptr = ptr;
      repeat (2) @(posedge clk);
      #1;
      data = reg_rdata;
   endtask : rd
endmodule : host_model
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam longint step = 10; // shortened four-hour step
   logic clk, rstn, cmp_out_a, cmp_out_b, reg_wr;
   logic converting, conv_channel, analog_power_on;
   logic [7:0] reg_ptr, reg_wdata, reg_rdata, d;
   logic [7:0] tv [3] = '{8'h41, 8'h43, 8'h7f}; // shortest, small, longest timeout
   logic [31:0] st = 32'd52; // xorshift state
   int n_errors = 0, n_compared = 0, n, i, n_ch, n_conv, n_two, n_off;
   conv_ctrl #(.step_cycles(step), .conv_cycles(8)) conv_ctrl_inst (.clk(clk), .rstn(rstn),
      .reg_wr(reg_wr), .reg_ptr(reg_ptr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .cmp_out_a(cmp_out_a), .cmp_out_b(cmp_out_b), .converting(converting),
      .conv_channel(conv_channel), .analog_power_on(analog_power_on));
   host_model host_model_inst (.clk(clk), .reg_wr(reg_wr), .reg_ptr(reg_ptr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      st ^= st << 13;
      st ^= st >> 17;
      st ^= st << 5;
      return st;
   endfunction : rnd
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_rng(input int got, input int lo, input int hi);
      n_compared++;
      if (got < lo || got > hi) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask : chk_rng
   // tallies channel changes, busy, channel-two busy and powered-down cycles
   task automatic watch(input int k);
      logic pc;
      pc = conv_channel;
      {n_ch, n_conv, n_two, n_off} = '0;
      repeat (k) begin
         @(posedge clk);
         #1;
         n_ch += int'(conv_channel !== pc);
         // unknown levels count as a change, busy, channel two or powered down
         n_conv += int'(converting !== 1'b0);
         n_two += int'(converting !== 1'b0 && conv_channel !== 1'b0);
         n_off += int'(analog_power_on !== 1'b1);
         pc = conv_channel;
      end
   endtask : watch
   task automatic conclude();
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   // about 2000 cycles are needed; 20000 means a hang
   initial begin
      #100000;
      n_errors++;
      conclude();
   end
   initial begin
      {rstn, cmp_out_a, cmp_out_b} = 3'b000;
      repeat (2) @(posedge clk);
      #1 rstn = 1'b1;
      host_model_inst.rd(8'h10, d);
      chk(d, 8'h40);
      host_model_inst.rd(8'h05, d);
      chk(d, 8'h00);
      for (i = 0; i < 4; i++) begin
         n = int'(rnd());
         host_model_inst.wr(8'h10, n[7:0]);
         host_model_inst.rd(8'h10, d);
         chk(d, {2'b01, n[5:0]});
      end
      host_model_inst.wr(8'h10, 8'h40);
      host_model_inst.wr(8'h0f, 8'h19);
      watch(700);
      chk_rng(n_off, 0, 0);
      chk_rng(n_ch, 8, 700);
      host_model_inst.wr(8'h0f, 8'h10);
      watch(60);
      chk_rng(n_conv + 100 * n_off, 0, 2);
      host_model_inst.wr(8'h0f, 8'h11);
      watch(100);
      chk_rng(n_two + 100 * int'(n_conv == 0), 0, 0);
      host_model_inst.wr(8'h0f, 8'h10);
      watch(20);
      host_model_inst.wr(8'h0f, 8'h1a);
      watch(100);
      chk_rng(n_conv, 16, 18);
      chk_rng(n_two, 6, 10);
      host_model_inst.wr(8'h0f, 8'h1b);
      watch(60);
      chk_rng(n_off + 100 * n_conv, 57, 60);
      foreach (tv[j]) begin
         host_model_inst.wr(8'h10, tv[j]);
         host_model_inst.wr(8'h0f, 8'h19);
         repeat (3) @(posedge clk);
         #1 {cmp_out_a, cmp_out_b} = rnd() & 1 ? 2'b10 : 2'b01;
         // held three cycles so stages two and three of the pin filter agree
         repeat (3) @(posedge clk);
         #1 {cmp_out_a, cmp_out_b} = 2'b00;
         n = 0;
         while (analog_power_on === 1'b1 && n < 700) begin
            @(posedge clk);
            #1 n++;
         end
         chk_rng(n, tv[j][5:0] * step, tv[j][5:0] * step + 10);
         watch(40);
         chk_rng(n_off, 40, 40);
      end
      host_model_inst.wr(8'h10, 8'h40);
      host_model_inst.wr(8'h0f, 8'h19);
      watch(20);
      chk_rng(n_off, 0, 2);
      conclude();
   end
endmodule : tb_top
bind conv_ctrl conv_ctrl_chk #(.step_cycles(step_cycles), .conv_cycles(conv_cycles))
   conv_ctrl_chk_inst (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_ptr(reg_ptr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmp_out_a(cmp_out_a),
   .cmp_out_b(cmp_out_b), .converting(converting), .conv_channel(conv_channel),
   .analog_power_on(analog_power_on));
`default_nettype wire
